/* File: rtl/vram_host_ctrl.sv */
// Host controller driving the dual-port video RAM random and serial ports
`timescale 1ns/1ps
module vram_host_ctrl
  import vram_host_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             reset,
  // Random port command side
  input  wire logic                             cmd_valid,
  output logic                                  cmd_ready,
  input  wire vram_host_pkg::op_e               cmd_op,
  input  wire logic [vram_host_pkg::ADDR_W-1:0] cmd_row,
  input  wire logic [vram_host_pkg::ADDR_W-1:0] cmd_col,
  input  wire logic [vram_host_pkg::DATA_W-1:0] cmd_data,
  input  wire logic [vram_host_pkg::DATA_W-1:0] cmd_mask,
  output logic                                  rsp_valid,
  output logic [vram_host_pkg::DATA_W-1:0]      rsp_data,
  // Serial read command side
  input  wire logic                             ser_req_valid,
  output logic                                  ser_req_ready,
  output logic                                  ser_word_valid,
  output logic [vram_host_pkg::DATA_W-1:0]      ser_word_data,
  // Device pins
  output logic                                  ras_n,
  output logic                                  cas_n,
  output logic                                  we_n,
  output logic                                  oe_n,
  output logic                                  transfer_trigger_n,
  output logic                                  flash_write_enable,
  output logic [vram_host_pkg::ADDR_W-1:0]      addr,
  input  wire logic [vram_host_pkg::DATA_W-1:0] random_io_lines_in,
  output logic [vram_host_pkg::DATA_W-1:0]      random_io_lines_out,
  output logic                                  random_io_lines_oe_n,
  output logic                                  serial_clock,
  output logic                                  serial_enable_n,
  input  wire logic [vram_host_pkg::DATA_W-1:0] serial_out_lines
);
  import vram_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  rstate_e             st_ff, nxt_st;             // Sequencer state
  logic [9:0]          cnt_ff, nxt_cnt;           // Phase timer
  op_e                 op_ff, nxt_op;             // Command in progress
  logic [ADDR_W-1:0]   col_ff, nxt_col;           // Held column address
  logic [DATA_W-1:0]   dat_ff, nxt_dat;           // Held write data
  logic                ras_ff, nxt_ras;           // Row strobe, low on
  logic                cas_ff, nxt_cas;           // Column strobe, low on
  logic                we_ff, nxt_we;             // Write strobe, low on
  logic                oe_ff, nxt_oe;             // Device output enable
  logic                dt_ff, nxt_dt;             // Transfer trigger
  logic                fwe_ff, nxt_fwe;           // Flash write pin
  logic [ADDR_W-1:0]   addr_ff, nxt_addr;         // Address pins
  logic [DATA_W-1:0]   io_ff, nxt_io;             // Data pins out
  logic                iooe_n_ff, nxt_iooe_n;     // Data pins enable
  logic                rv_ff, nxt_rv;             // Read answer pulse
  logic [DATA_W-1:0]   rd_ff, nxt_rd;             // Read answer data
  logic [DATA_W-1:0]   io_s1_ff, io_s2_ff;        // Pin synchroniser
  logic [9:0]          ref_ff, nxt_ref;           // Refresh interval timer
  logic                due_ff, nxt_due;           // Refresh pending
  logic                ser_quiet;                 // Serial clock at rest

  ////////////////////////////////////////////////////////////////////////////
  // Serial port runs on its own
  vram_serial_reader u_serial (
    .clk              (clk),
    .reset            (reset),
    .ser_req_valid    (ser_req_valid),
    .ser_req_ready    (ser_req_ready),
    .ser_word_valid   (ser_word_valid),
    .ser_word_data    (ser_word_data),
    .ser_quiet        (ser_quiet),
    .serial_clock     (serial_clock),
    .serial_enable_n  (serial_enable_n),
    .serial_out_lines (serial_out_lines)
  );

  // Commands wait while a refresh is owed
  assign cmd_ready            = (st_ff == ST_IDLE) && !due_ff;
  assign ras_n                = ras_ff;
  assign cas_n                = cas_ff;
  assign we_n                 = we_ff;
  assign oe_n                 = oe_ff;
  assign transfer_trigger_n   = dt_ff;
  assign flash_write_enable   = fwe_ff;
  assign addr                 = addr_ff;
  assign random_io_lines_out  = io_ff;
  assign random_io_lines_oe_n = iooe_n_ff;
  assign rsp_valid            = rv_ff;
  assign rsp_data             = rd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Refresh interval timer; a new due wins over its clear
  always_comb begin
    nxt_ref = ref_ff - CNT_ONE;
    nxt_due = due_ff;
    if (st_ff == ST_CBRRAS && cnt_ff == CNT_ZERO) begin
      nxt_due = 1'b0;
    end
    if (ref_ff == CNT_ZERO) begin
      nxt_ref = REF_CYC - CNT_ONE;
      nxt_due = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Random port sequencer
  always_comb begin
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_op     = op_ff;
    nxt_col    = col_ff;
    nxt_dat    = dat_ff;
    nxt_ras    = ras_ff;
    nxt_cas    = cas_ff;
    nxt_we     = we_ff;
    nxt_oe     = oe_ff;
    nxt_dt     = dt_ff;
    nxt_fwe    = fwe_ff;
    nxt_addr   = addr_ff;
    nxt_io     = io_ff;
    nxt_iooe_n = iooe_n_ff;
    nxt_rv     = 1'b0;
    nxt_rd     = rd_ff;
    if (cnt_ff != CNT_ZERO) begin
      nxt_cnt = cnt_ff - CNT_ONE;
    end
    case (st_ff)
      ST_IDLE: begin
        if (due_ff) begin
          // Column strobe first selects internal counter refresh
          nxt_cas = 1'b0;
          nxt_cnt = CSR_CYC - CNT_ONE;
          nxt_st  = ST_CBRCAS;
        end else if (cmd_valid) begin
          nxt_op   = cmd_op;
          nxt_col  = cmd_col;
          nxt_dat  = cmd_data;
          nxt_addr = cmd_row;
          nxt_cnt  = ASR_CYC - CNT_ONE;
          nxt_st   = ST_RSETUP;
          if (cmd_op == OP_CBRREF) begin
            nxt_cas = 1'b0;
            nxt_cnt = CSR_CYC - CNT_ONE;
            nxt_st  = ST_CBRCAS;
          end
          // Mask rides the data lines at row strobe
          if (cmd_op == OP_MWRITE || cmd_op == OP_FLASH) begin
            nxt_we     = 1'b0;
            nxt_io     = cmd_mask;
            nxt_iooe_n = 1'b0;
          end
          nxt_fwe = (cmd_op == OP_FLASH);
          nxt_dt  = (cmd_op != OP_XFER);
        end
      end
      ST_RSETUP: begin
        if (cnt_ff == CNT_ZERO) begin
          nxt_ras = 1'b0;
          nxt_st  = ST_ROW;
          // Row-only cycles hold row strobe the full width
          if (op_ff == OP_FLASH || op_ff == OP_RASREF) begin
            nxt_cnt = RAS_CYC - CNT_ONE;
          end else begin
            nxt_cnt = RCD_CYC - CNT_ONE;
          end
        end
      end
      ST_ROW: begin
        if (cnt_ff == CNT_ZERO) begin
          nxt_iooe_n = 1'b1;
          nxt_we     = 1'b1;
          nxt_fwe    = 1'b0;
          if (op_ff == OP_FLASH || op_ff == OP_RASREF) begin
            nxt_ras = 1'b1;
            nxt_cnt = RP_CYC - CNT_ONE;
            nxt_st  = ST_PRECH;
          end else begin
            nxt_addr = col_ff;
            nxt_cas  = 1'b0;
            nxt_cnt  = CAS_CYC - CNT_ONE;
            nxt_st   = ST_COL;
            if (op_ff == OP_READ) begin
              // Wait out synchroniser before sampling
              nxt_oe  = 1'b0;
              nxt_cnt = CAS_CYC + SYNC_WAIT - CNT_ONE;
            end else if (op_ff != OP_XFER) begin
              nxt_we     = 1'b0;
              nxt_io     = dat_ff;
              nxt_iooe_n = 1'b0;
            end
          end
        end
      end
      ST_COL: begin
        if (cnt_ff == CNT_ZERO) begin
          if (op_ff == OP_READ) begin
            nxt_rv = 1'b1;
            nxt_rd = io_s2_ff;
          end
          if (op_ff == OP_XFER) begin
            // Edge must never meet a serial clock rise
            if (ser_quiet && !ser_req_valid) begin
              nxt_dt = 1'b1;
              nxt_st = ST_DTRISE;
            end
          end else begin
            nxt_cas    = 1'b1;
            nxt_ras    = 1'b1;
            nxt_we     = 1'b1;
            nxt_oe     = 1'b1;
            nxt_iooe_n = 1'b1;
            nxt_cnt    = RP_CYC - CNT_ONE;
            nxt_st     = ST_PRECH;
          end
        end
      end
      ST_DTRISE: begin
        // Transfer closes like a random cycle and refreshes its row
        nxt_cas = 1'b1;
        nxt_ras = 1'b1;
        nxt_cnt = RP_CYC - CNT_ONE;
        nxt_st  = ST_PRECH;
      end
      ST_PRECH: begin
        if (cnt_ff == CNT_ZERO) begin
          nxt_st = ST_IDLE;
        end
      end
      ST_CBRCAS: begin
        if (cnt_ff == CNT_ZERO) begin
          nxt_ras = 1'b0;
          nxt_cnt = RAS_CYC - CNT_ONE;
          nxt_st  = ST_CBRRAS;
        end
      end
      ST_CBRRAS: begin
        if (cnt_ff == CNT_ZERO) begin
          nxt_ras = 1'b1;
          nxt_cas = 1'b1;
          nxt_cnt = RP_CYC - CNT_ONE;
          nxt_st  = ST_PRECH;
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= CNT_ZERO;
      op_ff     <= OP_READ;
      col_ff    <= '0;
      dat_ff    <= '0;
      ras_ff    <= 1'b1;
      cas_ff    <= 1'b1;
      we_ff     <= 1'b1;
      oe_ff     <= 1'b1;
      dt_ff     <= 1'b1;
      fwe_ff    <= 1'b0;
      addr_ff   <= '0;
      io_ff     <= '0;
      iooe_n_ff <= 1'b1;
      rv_ff     <= 1'b0;
      rd_ff     <= '0;
      io_s1_ff  <= '0;
      io_s2_ff  <= '0;
      ref_ff    <= REF_CYC - CNT_ONE;
      due_ff    <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      op_ff     <= nxt_op;
      col_ff    <= nxt_col;
      dat_ff    <= nxt_dat;
      ras_ff    <= nxt_ras;
      cas_ff    <= nxt_cas;
      we_ff     <= nxt_we;
      oe_ff     <= nxt_oe;
      dt_ff     <= nxt_dt;
      fwe_ff    <= nxt_fwe;
      addr_ff   <= nxt_addr;
      io_ff     <= nxt_io;
      iooe_n_ff <= nxt_iooe_n;
      rv_ff     <= nxt_rv;
      rd_ff     <= nxt_rd;
      io_s1_ff  <= random_io_lines_in;
      io_s2_ff  <= io_s1_ff;
      ref_ff    <= nxt_ref;
      due_ff    <= nxt_due;
    end
  end
endmodule : vram_host_ctrl

/* File: rtl/vram_host_pkg.sv */
// Constants, timing counts and enumerations for the video RAM host controller
// Function
// - Write mask sent on data lines at row strobe
// - Ports asynchronous except special transfer cycle
// - Host issues row-only or column-before-row refresh cycles
// - Output enable floats random data lines
package vram_host_pkg;
  // Array geometry of the larger variant
  localparam int          ROWS       = 512;
  localparam int          ADDR_W     = 9;
  localparam int          DATA_W     = 4;
  // Clock and strobe timing
  localparam int          CLK_NS     = 25;
  localparam int          T_ASR_NS   = 25;
  localparam int          T_RCD_NS   = 50;
  localparam int          T_RAS_NS   = 100;
  localparam int          T_CAS_NS   = 50;
  localparam int          T_RP_NS    = 100;
  localparam int          T_CSR_NS   = 25;
  localparam int          T_SC_NS    = 50;
  localparam int          T_REF_NS   = 15625;
  localparam int          SYNC_CYC   = 2;
  // Cycle counts, least times rounded up
  localparam logic [9:0]  ASR_CYC    = 10'((T_ASR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  RCD_CYC    = 10'((T_RCD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  RAS_CYC    = 10'((T_RAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  CAS_CYC    = 10'((T_CAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  RP_CYC     = 10'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  CSR_CYC    = 10'((T_CSR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0]  SC_CYC     = 10'((T_SC_NS + CLK_NS - 1) / CLK_NS);
  // Refresh interval is a longest time, rounded down
  localparam logic [9:0]  REF_CYC    = 10'(T_REF_NS / CLK_NS);
  localparam logic [9:0]  SYNC_WAIT  = 10'(SYNC_CYC);
  localparam logic [9:0]  CNT_ONE    = 10'h001;
  localparam logic [9:0]  CNT_ZERO   = 10'h000;
  // Host command codes
  typedef enum logic [2:0] {
    OP_READ     = 3'h0,
    OP_WRITE    = 3'h1,
    OP_MWRITE   = 3'h2,
    OP_FLASH    = 3'h3,
    OP_XFER     = 3'h4,
    OP_RASREF   = 3'h5,
    OP_CBRREF   = 3'h6
  } op_e;
  // Random port sequencer states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_RSETUP   = 4'h1,
    ST_ROW      = 4'h2,
    ST_COL      = 4'h3,
    ST_DTRISE   = 4'h4,
    ST_PRECH    = 4'h5,
    ST_CBRCAS   = 4'h6,
    ST_CBRRAS   = 4'h7
  } rstate_e;
  // Serial reader states
  typedef enum logic [1:0] {
    SS_IDLE     = 2'h0,
    SS_HIGH     = 2'h1,
    SS_LOW      = 2'h2
  } sstate_e;
endpackage : vram_host_pkg

/* File: rtl/vram_serial_reader.sv */
// Serial read port driver: clocks words out of the device register
`timescale 1ns/1ps
module vram_serial_reader
  import vram_host_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         ser_req_valid,
  output logic                              ser_req_ready,
  output logic                              ser_word_valid,
  output logic [vram_host_pkg::DATA_W-1:0]  ser_word_data,
  output logic                              ser_quiet,
  output logic                              serial_clock,
  output logic                              serial_enable_n,
  input  wire logic [vram_host_pkg::DATA_W-1:0] serial_out_lines
);
  import vram_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  sstate_e             sst_ff, nxt_sst;           // Phase of serial clock
  logic [9:0]          scnt_ff, nxt_scnt;         // Phase timer
  logic                sclk_ff, nxt_sclk;         // Serial clock pin
  logic                sen_n_ff, nxt_sen_n;       // Serial select, low on
  logic                wv_ff, nxt_wv;             // Word pulse
  logic [DATA_W-1:0]   wd_ff, nxt_wd;             // Captured word
  logic [DATA_W-1:0]   so_s1_ff, so_s2_ff;        // Pin synchroniser

  assign ser_req_ready   = (sst_ff == SS_IDLE);
  assign ser_quiet       = (sst_ff == SS_IDLE);
  assign serial_clock    = sclk_ff;
  assign serial_enable_n = sen_n_ff;
  assign ser_word_valid  = wv_ff;
  assign ser_word_data   = wd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Next phase, clock edge and capture
  always_comb begin
    nxt_sst   = sst_ff;
    nxt_scnt  = scnt_ff;
    nxt_sclk  = sclk_ff;
    nxt_sen_n = sen_n_ff;
    nxt_wv    = 1'b0;
    nxt_wd    = wd_ff;
    if (scnt_ff != CNT_ZERO) begin
      nxt_scnt = scnt_ff - CNT_ONE;
    end
    case (sst_ff)
      SS_IDLE: begin
        // Outputs float while nobody reads
        nxt_sen_n = 1'b1;
        if (ser_req_valid) begin
          nxt_sen_n = 1'b0;
          nxt_sclk  = 1'b1;
          nxt_scnt  = SC_CYC - CNT_ONE;
          nxt_sst   = SS_HIGH;
        end
      end
      SS_HIGH: begin
        if (scnt_ff == CNT_ZERO) begin
          nxt_sclk = 1'b0;
          nxt_scnt = SC_CYC + SYNC_WAIT - CNT_ONE;
          nxt_sst  = SS_LOW;
        end
      end
      SS_LOW: begin
        // Word settled and crossed the synchroniser
        if (scnt_ff == CNT_ZERO) begin
          nxt_wv  = 1'b1;
          nxt_wd  = so_s2_ff;
          nxt_sst = SS_IDLE;
        end
      end
      default: begin
        nxt_sst = SS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sst_ff   <= SS_IDLE;
      scnt_ff  <= CNT_ZERO;
      sclk_ff  <= 1'b0;
      sen_n_ff <= 1'b1;
      wv_ff    <= 1'b0;
      wd_ff    <= '0;
      so_s1_ff <= '0;
      so_s2_ff <= '0;
    end else begin
      sst_ff   <= nxt_sst;
      scnt_ff  <= nxt_scnt;
      sclk_ff  <= nxt_sclk;
      sen_n_ff <= nxt_sen_n;
      wv_ff    <= nxt_wv;
      wd_ff    <= nxt_wd;
      so_s1_ff <= serial_out_lines;
      so_s2_ff <= so_s1_ff;
    end
  end
endmodule : vram_serial_reader

/* File: testbench/vram_device_model.sv */
// Behavioural dual-port video RAM answering the host controller
`timescale 1ns/1ps
module vram_device_model
  import vram_host_pkg::*;
#(
  parameter int         NROWS  = ROWS,  // Rows and register length
  parameter logic [3:0] COLOUR = 4'ha   // Flash colour register value
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic              transfer_trigger_n,
  input  wire logic              flash_write_enable,
  input  wire logic [DATA_W-1:0] io_in,
  input  wire logic              serial_clock,
  input  wire logic              serial_enable_n,
  output logic [DATA_W-1:0]      io_out,
  output logic [DATA_W-1:0]      so_lines,
  output int                     ref_ptr
);
  logic [3:0] mem [int];        // Storage, absent words read as zero
  logic [3:0] ser_reg [NROWS];  // Serial data register
  logic [8:0] row_l, col_l, ptr;
  logic [3:0] wmask, dval, sval;
  logic       xfer, den;

  function automatic int k(logic [8:0] r, logic [8:0] c);
    return int'({r, c});
  endfunction : k
  function automatic logic [3:0] rd(int a);
    return mem.exists(a) ? mem[a] : 4'h0;
  endfunction : rd

  initial begin
    {row_l, col_l, ptr, wmask, dval, sval, xfer, den} = '0;
    ref_ptr = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Row strobe: latch row, write mask and cycle kind after pins settle
  always @(negedge ras_n) begin
    #1;
    row_l = addr;
    xfer = !transfer_trigger_n;
    wmask = !we_n ? io_in : 4'hf;
    if (!cas_n)
      ref_ptr = (ref_ptr + 1) % NROWS;
    else if (flash_write_enable)
      for (int c = 0; c < NROWS; c++)
        mem[k(row_l, 9'(c))] = (rd(k(row_l, 9'(c))) & ~wmask) | (COLOUR & wmask);
  end
  // Column strobe: masked write or unlatched read
  always @(negedge cas_n) begin
    #1;
    col_l = addr;
    if (!ras_n && !xfer && !we_n)
      mem[k(row_l, col_l)] = (rd(k(row_l, col_l)) & ~wmask) | (io_in & wmask);
    if (!ras_n && !xfer && we_n) begin
      dval = rd(k(row_l, col_l));
      den = 1'b1;
    end
  end
  // Read data stays under column strobe control
  always @(posedge cas_n) den = 1'b0;
  // Released lines show the inverse of the last word
  assign io_out = (den && !oe_n) ? dval : ~dval;
  ////////////////////////////////////////////////////////////////////////////
  // Rising trigger loads the row and the start column
  always @(posedge transfer_trigger_n) begin
    if (xfer && !ras_n) begin
      for (int c = 0; c < NROWS; c++)
        ser_reg[c] = rd(k(row_l, 9'(c)));
      ptr = col_l;
    end
  end
  // Serial shift, independent of the random port
  always @(posedge serial_clock) begin
    #1;
    if (!serial_enable_n) begin
      sval = ser_reg[ptr];
      ptr = ptr + 9'h001;
    end
  end
  assign so_lines = !serial_enable_n ? sval : ~sval;
endmodule : vram_device_model

/* File: testbench/vram_host_ctrl_sva.sv */
// Port assertions for the video RAM host controller
`timescale 1ns/1ps
module vram_host_ctrl_sva
  import vram_host_pkg::*;
(
  input wire logic                             clk,
  input wire logic                             reset,
  input wire logic                             cmd_valid,
  input wire logic                             cmd_ready,
  input wire vram_host_pkg::op_e               cmd_op,
  input wire logic [vram_host_pkg::ADDR_W-1:0] cmd_row,
  input wire logic                             rsp_valid,
  input wire logic                             ser_req_valid,
  input wire logic                             ser_req_ready,
  input wire logic                             ser_word_valid,
  input wire logic                             ras_n,
  input wire logic                             cas_n,
  input wire logic                             we_n,
  input wire logic                             oe_n,
  input wire logic                             transfer_trigger_n,
  input wire logic [vram_host_pkg::ADDR_W-1:0] addr,
  input wire logic                             random_io_lines_oe_n,
  input wire logic                             serial_clock,
  input wire logic                             serial_enable_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic take;  // Command accepted at this edge
  assign take = cmd_valid && cmd_ready;

  a_read_answer: assert property (take && cmd_op == OP_READ |-> ##[7:8] rsp_valid)
    else $error("read answer missing");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("read answer too long");
  a_row_addr: assert property (take && cmd_op != OP_CBRREF |=> addr == $past(cmd_row))
    else $error("row address not presented");
  a_ras_width: assert property ($fell(ras_n) |-> !ras_n [*4])
    else $error("row strobe too short");
  a_precharge_time: assert property ($rose(ras_n) |-> ras_n [*4])
    else $error("precharge too short");
  a_cas_delay: assert property ($fell(cas_n) |-> ras_n || !$past(ras_n, 2))
    else $error("column strobe too early");
  a_no_contend: assert property (!random_io_lines_oe_n |-> oe_n)
    else $error("data line contention");
  a_mask_drive: assert property ($fell(ras_n) && !we_n |-> !random_io_lines_oe_n)
    else $error("write mask not driven");
  a_xfer_rise: assert property ($rose(transfer_trigger_n) |-> !ras_n && serial_enable_n)
    else $error("transfer edge misplaced");
  a_ser_answer: assert property (ser_req_valid && ser_req_ready |-> ##[6:7] ser_word_valid)
    else $error("serial word missing");
  a_ser_clk_idle: assert property (serial_enable_n |-> !serial_clock)
    else $error("serial clock while deselected");
  a_ready_idle: assert property (cmd_ready |-> ras_n && cas_n)
    else $error("ready during a cycle");
endmodule : vram_host_ctrl_sva

bind vram_host_ctrl vram_host_ctrl_sva vram_host_ctrl_sva_inst (
  .clk, .reset, .cmd_valid, .cmd_ready, .cmd_op, .cmd_row, .rsp_valid,
  .ser_req_valid, .ser_req_ready, .ser_word_valid, .ras_n, .cas_n, .we_n,
  .oe_n, .transfer_trigger_n, .addr, .random_io_lines_oe_n, .serial_clock,
  .serial_enable_n
);

/* File: testbench/dual_port_video_ram_tb_top.sv */
// Self-checking bench for the video RAM host controller
`timescale 1ns/1ps
module dual_port_video_ram_tb_top;
  import vram_host_pkg::*;
  localparam logic [3:0] COLOUR = 4'h9;  // Flash colour, arbitrary
  logic       clk, reset, cmd_valid, ser_req_valid, cmd_ready, rsp_valid;
  logic       ser_req_ready, ser_word_valid, ras_n, cas_n, we_n, oe_n;
  logic       transfer_trigger_n, flash_write_enable, random_io_lines_oe_n;
  logic       serial_clock, serial_enable_n;
  op_e        cmd_op;
  logic [8:0] cmd_row, cmd_col, addr, r, c, srow, sp;
  logic [3:0] cmd_data, cmd_mask, rsp_data, ser_word_data, io_dev, io_wire;
  logic [3:0] random_io_lines_out, serial_out_lines;
  logic [3:0] rq [$], sq [$], em [int];
  int         seed = 56102, bad_count = 0, samples_checked = 0, ref_ptr, r0;

  always #12.5 clk = ~clk;
  // Shared data lines: host when enabled, else the device
  assign io_wire = !random_io_lines_oe_n ? random_io_lines_out : io_dev;

  vram_host_ctrl vram_host_ctrl_inst (.clk, .reset, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_row, .cmd_col, .cmd_data, .cmd_mask, .rsp_valid, .rsp_data,
    .ser_req_valid, .ser_req_ready, .ser_word_valid, .ser_word_data, .ras_n,
    .cas_n, .we_n, .oe_n, .transfer_trigger_n, .flash_write_enable, .addr,
    .random_io_lines_in(io_wire), .random_io_lines_out, .random_io_lines_oe_n,
    .serial_clock, .serial_enable_n, .serial_out_lines);
  vram_device_model #(.COLOUR(COLOUR)) vram_device_model_inst (.addr, .ras_n,
    .cas_n, .we_n, .oe_n, .transfer_trigger_n, .flash_write_enable,
    .io_in(io_wire), .serial_clock, .serial_enable_n, .io_out(io_dev),
    .so_lines(serial_out_lines), .ref_ptr);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] ex(logic [8:0] rr, logic [8:0] cc);
    return em.exists(int'({rr, cc})) ? em[int'({rr, cc})] : 4'h0;
  endfunction : ex
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Wait until the random port is free again
  task automatic idle();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (cmd_ready !== 1'b1) bad_count++;
  endtask : idle
  // One command held until taken
  task automatic cmd(op_e op, logic [8:0] rr, cc, logic [3:0] d, m);
    @(negedge clk);
    cmd_op = op;
    cmd_row = rr;
    cmd_col = cc;
    cmd_data = d;
    cmd_mask = m;
    cmd_valid = 1'b1;
    idle();
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : cmd
  // Write and note the expected contents
  task automatic wr(op_e op, logic [8:0] rr, cc, logic [3:0] d, m);
    if (op == OP_FLASH)
      for (int i = 0; i < ROWS; i++)
        em[int'({rr, 9'(i)})] = (ex(rr, 9'(i)) & ~m) | (COLOUR & m);
    else
      em[int'({rr, cc})] = (ex(rr, cc) & ~m) | (d & m);
    cmd(op, rr, cc, d, m);
  endtask : wr
  task automatic rdc(logic [8:0] rr, cc);
    rq.push_back(ex(rr, cc));
    cmd(OP_READ, rr, cc, 4'h0, 4'h0);
  endtask : rdc
  task automatic xf(logic [8:0] rr, cc);
    cmd(OP_XFER, rr, cc, 4'h0, 4'h0);
    idle();
    srow = rr;
    sp = cc;
  endtask : xf
  // One serial word, expected from the tracked start column
  task automatic ser();
    sq.push_back(ex(srow, sp));
    sp = sp + 9'h001;
    @(negedge clk);
    ser_req_valid = 1'b1;
    while (ser_req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    ser_req_valid = 1'b0;
  endtask : ser

  ////////////////////////////////////////////////////////////////////////////
  // Result watchers pair each answer with the oldest note
  always @(negedge clk) begin
    if (rsp_valid === 1'b1)
      check("rsp_data", rsp_data, rq.pop_front());
    if (ser_word_valid === 1'b1)
      check("ser_word_data", ser_word_data, sq.pop_front());
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial begin
    {clk, cmd_valid, ser_req_valid, srow, sp} = '0;
    reset = 1'b1;
    {cmd_row, cmd_col, cmd_data, cmd_mask} = '0;
    cmd_op = OP_READ;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    check("strobes", {ras_n, cas_n, we_n, oe_n}, 4'hf);
    check("idle pins", {transfer_trigger_n, random_io_lines_oe_n,
      serial_enable_n, serial_clock}, 4'he);
    // Random writes, each read straight back
    repeat (6) begin
      r = 9'($random(seed));
      c = 9'($random(seed));
      wr(OP_WRITE, r, c, 4'($random(seed)), 4'hf);
      rdc(r, c);
    end
    wr(OP_MWRITE, r, c, 4'($random(seed)), 4'h6);
    rdc(r, c);
    // Row A for the first transfer, row B written then flashed
    wr(OP_WRITE, 9'h003, 9'h005, 4'($random(seed)), 4'hf);
    wr(OP_WRITE, 9'h003, 9'h006, 4'($random(seed)), 4'hf);
    wr(OP_WRITE, 9'h1a0, 9'h1fe, 4'($random(seed)), 4'hf);
    wr(OP_FLASH, 9'h1a0, 9'h000, 4'h0, 4'h5);
    rdc(9'h1a0, 9'h1fe);
    // Refresh cycles of both kinds
    r0 = ref_ptr;
    cmd(OP_RASREF, 9'h1a0, 9'h000, 4'h0, 4'h0);
    cmd(OP_CBRREF, 9'h000, 9'h000, 4'h0, 4'h0);
    idle();
    check("refresh counter", {3'h0, ref_ptr != r0}, 4'h1);
    // Transfer row A, then row B while a serial read runs
    xf(9'h003, 9'h005);
    ser();
    fork
      ser();
      xf(9'h1a0, 9'h1fe);
    join
    repeat (3) ser();
    // Idle past the automatic refresh interval
    r0 = ref_ptr;
    repeat (700) @(negedge clk);
    check("auto refresh", {3'h0, ref_ptr != r0}, 4'h1);
    rdc(r, c);
    r0 = 0;
    while ((rq.size() > 0 || sq.size() > 0) && r0 < 200) begin
      @(negedge clk);
      r0++;
    end
    if (rq.size() + sq.size() > 0) bad_count++;
    end_sim();
  end
endmodule : dual_port_video_ram_tb_top
